// ---- logic/scan_select.sv ----
/*
 * Analog scan input select register with an automatic scan sequencer
 * and a sixteen-word result buffer.
 * Assumes a plain register port on ref_clk and a converter that answers
 * each start pulse with a done pulse and a 10-bit result.
 */
//
// Summary of operation
// - upper sixteen register bits read zero and ignore writes.
// - a set pick bit includes that source in the scan.
// - pick bits 0 to 12 select the external pin of the same index.
// - bit 13 charge-time unit, bit 14 internal reference, bit 15 ground.
// - all bits writable; missing pins convert the low reference level.
// - results go into a sixteen-word buffer filled by the scan.
`timescale 1ns/10ps
`include "scan_consts.svh"

module scan_select #(
	parameter logic [15:0] PIN_PRESENT = `PIN_COUNT_DEFAULT  // bonded pins
) (
	input  wire logic        ref_clk,      // 200 MHz clock
	input  wire logic        arst_n,       // async reset, active low
	input  wire logic [7:0]  addr,         // register byte address
	input  wire logic [31:0] wdata,        // write data
	input  wire logic        wr,           // write strobe
	input  wire logic        rd,           // read strobe
	output logic      [31:0] rdata,        // read data, cycle after rd
	output logic             conv_start,   // start pulse to converter
	output logic      [3:0]  conv_source,  // mux select to converter
	output logic             conv_low_ref, // convert low reference level
	input  wire logic        conv_done,    // converter done pulse
	input  wire logic [9:0]  conv_result   // converter result
);

	scan_pkg::bus_req_type    req;
	scan_pkg::pick_type       pick;
	scan_pkg::scan_state_type state_reg, state_next;

	logic [15:0] scan_pick_bits_reg, scan_pick_bits_next;
	logic        scan_en_reg, scan_en_next;
	logic [31:0] rdata_next;
	logic [3:0]  cur_reg, cur_next;
	logic        first_reg, first_next;
	logic [3:0]  fill_reg, fill_next;
	logic        pass_done_reg, pass_done_next;
	logic        start_next;
	logic [3:0]  src_next;
	logic        low_next;
	logic [9:0]  result_mem [`RESULT_WORDS];

	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	scan_source_pick u_pick (
		.pick_mask   (scan_pick_bits_reg),
		.pin_present (PIN_PRESENT),
		.current     (cur_reg),
		.first       (first_reg),
		.pick        (pick)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// ------------------------------------------
	// register writes and sequencer
	// ------------------------------------------
	always_comb begin
		scan_pick_bits_next = scan_pick_bits_reg;
		scan_en_next        = scan_en_reg;
		state_next          = state_reg;
		cur_next            = cur_reg;
		first_next          = first_reg;
		fill_next           = fill_reg;
		pass_done_next      = pass_done_reg;
		start_next          = 1'b0;
		src_next            = conv_source;
		low_next            = conv_low_ref;
		if (req.wr && hit(req.addr, `SCAN_SEL_OFFSET)) begin
			scan_pick_bits_next = req.wdata[15:0];
		end
		if (req.wr && hit(req.addr, `SCAN_CTRL_OFFSET)) begin
			scan_en_next = req.wdata[`SCAN_CTRL_EN_BIT];
		end
		case (state_reg)
			scan_pkg::ST_IDLE: begin
				first_next = 1'b1;
				fill_next  = 4'h0;
				if (scan_en_reg && pick.valid) begin
					src_next       = pick.source;
					low_next       = pick.use_low_ref;
					cur_next       = pick.source;
					first_next     = 1'b0;
					start_next     = 1'b1;
					pass_done_next = 1'b0;
					state_next     = scan_pkg::ST_CONVERT;
				end
			end
			scan_pkg::ST_CONVERT: begin
				if (conv_done) begin
					state_next = scan_pkg::ST_STORE;
				end
			end
			scan_pkg::ST_STORE: begin
				fill_next = fill_reg + 4'h1;
				if (fill_reg == 4'hf) begin
					pass_done_next = 1'b1;
				end
				if (scan_en_reg && pick.valid) begin
					src_next   = pick.source;
					low_next   = pick.use_low_ref;
					cur_next   = pick.source;
					start_next = 1'b1;
					state_next = scan_pkg::ST_CONVERT;
				end else begin
					// next pass restarts from the lowest pick
					first_next = 1'b1;
					state_next = scan_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = scan_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scan_pick_bits_reg <= `SCAN_SEL_RESET;
			scan_en_reg        <= `SCAN_CTRL_RESET;
			state_reg          <= scan_pkg::ST_IDLE;
			cur_reg            <= 4'h0;
			first_reg          <= 1'b1;
			fill_reg           <= 4'h0;
			pass_done_reg      <= 1'b0;
			conv_start         <= 1'b0;
			conv_source        <= 4'h0;
			conv_low_ref       <= 1'b0;
		end else begin
			scan_pick_bits_reg <= scan_pick_bits_next;
			scan_en_reg        <= scan_en_next;
			state_reg          <= state_next;
			cur_reg            <= cur_next;
			first_reg          <= first_next;
			fill_reg           <= fill_next;
			pass_done_reg      <= pass_done_next;
			conv_start         <= start_next;
			conv_source        <= src_next;
			conv_low_ref       <= low_next;
		end
	end

	// ------------------------------------------
	// result buffer, no reset: contents are data
	// ------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (state_reg == scan_pkg::ST_CONVERT && conv_done) begin
			result_mem[fill_reg] <= conv_result;
		end
	end

	// ------------------------------------------
	// read path
	// ------------------------------------------
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (req.rd) begin
			if (hit(req.addr, `SCAN_SEL_OFFSET)) begin
				rdata_next = {16'h0000, scan_pick_bits_reg};
			end else if (hit(req.addr, `SCAN_CTRL_OFFSET)) begin
				rdata_next = {31'h0000_0000, scan_en_reg};
			end else if (hit(req.addr, `SCAN_STATUS_OFFSET)) begin
				rdata_next = {16'h0000, 3'h0, pass_done_reg, fill_reg,
					1'b0, state_reg, cur_reg};
			end else if (req.addr[7:6] == 2'(`SCAN_RESULT_OFFSET >> 6) && req.addr[1:0] == 2'b00) begin
				rdata_next = {22'h00_0000, result_mem[req.addr[`RESULT_IDX_MSB:`RESULT_IDX_LSB]]};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= rdata_next;
		end
	end

endmodule : scan_select

// ---- logic/scan_consts.svh ----
/*
 * Constants for the analog scan input select block: register offsets,
 * field positions, reset values and source indices.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SCAN_CONSTS_SVH
`define SCAN_CONSTS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SCAN_SEL_OFFSET      8'h00
`define SCAN_CTRL_OFFSET     8'h04
`define SCAN_STATUS_OFFSET   8'h08
`define SCAN_RESULT_OFFSET   8'h40

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SCAN_SEL_RESET       16'h0000
`define SCAN_CTRL_EN_BIT     0
`define SCAN_CTRL_RESET      1'b0
`define RESULT_WORDS         16
`define RESULT_IDX_MSB       5
`define RESULT_IDX_LSB       2

// ----------------------------------------
// sources above the external pins, and the default bonded-pin mask
// ----------------------------------------
`define SRC_CHARGE_TIME      4'hd
`define SRC_INT_REF          4'he
`define SRC_GROUND           4'hf
`define PIN_COUNT_DEFAULT    16'h1fff

`endif

// ---- logic/scan_pkg.sv ----
/*
 * Types shared by the scan select block and its source picker.
 * Assumes the constants header is also available.
 */
package scan_pkg;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b001,
		ST_CONVERT = 3'b010,
		ST_STORE   = 3'b100
	} scan_state_type;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_type;

	typedef struct packed {
		logic       valid;
		logic [3:0] source;
		logic       use_low_ref;
	} pick_type;

endpackage : scan_pkg

// ---- logic/scan_source_pick.sv ----
/*
 * Finds the next selected scan source above the current one, wrapping
 * to the lowest selected source; flags external pin sources 0 to 12 without a bonded pin.
 * Assumes purely combinational use on the caller's clock.
 */
`timescale 1ns/10ps
`include "scan_consts.svh"

module scan_source_pick (
	input  wire logic [15:0]        pick_mask,    // selected sources
	input  wire logic [15:0]        pin_present,  // pins bonded out
	input  wire logic [3:0]         current,      // last source converted
	input  wire logic               first,        // start of a scan pass
	output scan_pkg::pick_type      pick          // next source
);

	logic [4:0] cand;
	logic       found;
	logic [3:0] nxt;

	// ------------------------------------------
	// ascending search with wrap
	// ------------------------------------------
	always_comb begin
		cand  = 5'h00;
		found = 1'b0;
		nxt   = 4'h0;
		for (int i = 1; i <= 16; i++) begin
			cand = first ? 5'(i - 1) : 5'((32'(current) + i) % 16);
			if (!found && pick_mask[cand[3:0]]) begin
				found = 1'b1;
				nxt   = cand[3:0];
			end
		end
		pick.valid       = found;
		pick.source      = nxt;
		pick.use_low_ref = (nxt < `SRC_CHARGE_TIME) && !pin_present[nxt];
	end

endmodule : scan_source_pick

// ---- dv/scan_select_assertions.sv ----
/* port checker for scan_select
 * assumes bind onto every scan_select instance */
`timescale 1ns/10ps
`include "scan_consts.svh"
module scan_select_assertions #(
	parameter logic [15:0] PIN_PRESENT = `PIN_COUNT_DEFAULT // bonded pins
) (
	input wire logic        ref_clk,      // clock
	input wire logic        arst_n,       // reset
	input wire logic [7:0]  addr,         // address
	input wire logic [31:0] wdata,        // write data
	input wire logic        wr,           // write
	input wire logic        rd,           // read
	input wire logic [31:0] rdata,        // read data
	input wire logic        conv_start,   // start
	input wire logic [3:0]  conv_source,  // source
	input wire logic        conv_low_ref, // low ref
	input wire logic        conv_done,    // done
	input wire logic [9:0]  conv_result   // result
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// --------------------------------
	// shadow of mask, enable, progress
	// --------------------------------
	logic [15:0] mask_reg;
	logic        en_reg;
	logic        busy_reg;
	logic [3:0]  prev_reg;
	// bounded search: a zero mask must not hang the tool
	function automatic logic [3:0] nxt(input logic [15:0] m, input logic [3:0] p);
		nxt = p + 4'h1;
		repeat (15) if (!m[nxt]) nxt = nxt + 4'h1;
	endfunction : nxt
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_reg <= 16'h0000;
			en_reg <= 1'b0;
			busy_reg <= 1'b0;
			prev_reg <= 4'hf;
		end else begin
			busy_reg <= conv_start | (busy_reg & !conv_done);
			if (conv_start) prev_reg <= conv_source;
			if (wr && addr == `SCAN_SEL_OFFSET) mask_reg <= wdata[15:0];
			if (wr && addr == `SCAN_CTRL_OFFSET) begin
				en_reg <= wdata[`SCAN_CTRL_EN_BIT];
				prev_reg <= 4'hf;
			end
		end
	end
	a_upper_read_zero: assert property (rd && addr == `SCAN_SEL_OFFSET |=> rdata[31:16] == 16'h0000)
		else $error("select upper half not zero");
	a_rdata_idle: assert property (!rd |=> rdata == 32'h0000_0000)
		else $error("read data outside read cycle");
	a_start_pulse: assert property (conv_start |=> !conv_start)
		else $error("start longer than one cycle");
	a_start_needs_pick: assert property (conv_start |-> $past(en_reg) && $past(mask_reg) != 16'h0000)
		else $error("start without enable or pick");
	a_scan_order: assert property (conv_start |-> conv_source == nxt($past(mask_reg), $past(prev_reg)))
		else $error("source out of scan order");
	a_pin_low_ref: assert property (conv_start && conv_source <= 4'hc |-> conv_low_ref == !PIN_PRESENT[conv_source])
		else $error("low reference flag wrong for pin");
	a_extra_no_low: assert property (conv_start && conv_source > 4'hc |-> !conv_low_ref)
		else $error("low reference on internal source");
	a_store_then_start: assert property (conv_done && busy_reg ##1 en_reg && mask_reg != 16'h0000 |=> conv_start)
		else $error("no start after store");
	a_source_held: assert property (!conv_start |-> $stable(conv_source) && $stable(conv_low_ref))
		else $error("source moved between starts");
	c_missing_pin: cover property (conv_start && conv_low_ref);
	c_ground: cover property (conv_start && conv_source == 4'hf);
	c_read_back: cover property (rd ##1 rdata != 32'h0000_0000);
endmodule : scan_select_assertions
bind scan_select scan_select_assertions #(.PIN_PRESENT(PIN_PRESENT)) u_scan_select_assertions (
	.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.conv_start(conv_start), .conv_source(conv_source), .conv_low_ref(conv_low_ref),
	.conv_done(conv_done), .conv_result(conv_result));

// ---- dv/scan_select_tb.sv ----
/* self-checking bench for scan_select
 * assumes the port checker is bound from its own file */
`timescale 1ns/10ps
`include "scan_consts.svh"
module scan_select_tb;
	localparam logic [15:0] PINS = 16'h0e3f; // pins 6-8 and 12 absent
	logic        ref_clk;
	logic        arst_n;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr;
	logic        rd;
	logic        rd_d;
	logic [31:0] rdata;
	logic        conv_start;
	logic [3:0]  conv_source;
	logic        conv_low_ref;
	logic        conv_done;
	logic [9:0]  conv_result;
	logic        busy;
	logic [31:0] v;
	logic [31:0] rd_q[$];
	logic [4:0]  src_q[$];
	logic [9:0]  res[16];
	int          err_total;
	int          checked;
	int          starts;
	int          fill;
	int          cycles;
	integer      seed;
	scan_select #(.PIN_PRESENT(PINS)) u_scan_select (.ref_clk(ref_clk), .arst_n(arst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .conv_start(conv_start), .conv_source(conv_source),
		.conv_low_ref(conv_low_ref), .conv_done(conv_done), .conv_result(conv_result));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_rd
	task automatic cmp_src(input logic [4:0] got, input logic [4:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_src
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		@(posedge ref_clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		if (!w) rd_q.push_back(e);
		@(posedge ref_clk);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	// -----------------------------
	// watcher: reads, starts, hangs
	// -----------------------------
	always @(posedge ref_clk) begin
		cycles++;
		if (rd_d) cmp_rd(rdata, rd_q.pop_front());
		rd_d = rd;
		if (conv_start) begin
			starts++;
			cmp_src({conv_low_ref, conv_source}, src_q.size() > 0 ? src_q.pop_front() : 5'h1f);
		end
		if (cycles == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	// converter stand-in; slow enough that a disable lands first
	initial begin
		conv_done = 1'b0;
		conv_result = 10'h000;
		busy = 1'b0;
		forever begin
			@(posedge ref_clk);
			if (conv_start) begin
				busy = 1'b1;
				repeat (3 + $unsigned($random(seed)) % 4) @(posedge ref_clk);
				v = $random(seed);
				res[fill % 16] = v[9:0];
				fill++;
				conv_done <= 1'b1;
				conv_result <= v[9:0];
				@(posedge ref_clk);
				conv_done <= 1'b0;
				busy = 1'b0;
			end
		end
	end
	task automatic scan(input logic [15:0] m, input int n);
		logic [3:0] p;
		int i;
		p = 4'hf;
		fill = 0;
		starts = 0;
		bus(1'b1, `SCAN_SEL_OFFSET, {16'hffff, m}, 0);
		for (i = 0; i < n; i++) begin
			do p = p + 4'h1; while (!m[p]);
			src_q.push_back({p <= 4'hc && !PINS[p], p});
		end
		bus(1'b1, `SCAN_CTRL_OFFSET, 32'h0000_0001, 0);
		for (i = 0; i < 4000 && starts < n; i++) @(posedge ref_clk);
		bus(1'b1, `SCAN_CTRL_OFFSET, 32'h0000_0000, 0);
		for (i = 0; i < 100 && busy; i++) @(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
		bus(1'b0, `SCAN_SEL_OFFSET, 0, {16'h0000, m});
		bus(1'b0, `SCAN_STATUS_OFFSET, 0, {19'h0, n >= 16, 4'h0, 1'b0, 3'b001, p});
		for (i = 0; i < 16 && i < n; i++) bus(1'b0, `SCAN_RESULT_OFFSET + 8'(4 * i), 0, {22'h0, res[i]});
		$display("scan %h done", m);
	endtask : scan
	initial begin
		seed = 32'h1795;
		arst_n = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr = 1'b0;
		rd = 1'b0;
		rd_d = 1'b0;
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		bus(1'b0, `SCAN_SEL_OFFSET, 0, 32'h0000_0000);
		bus(1'b0, `SCAN_CTRL_OFFSET, 0, 32'h0000_0000);
		bus(1'b0, 8'h20, 0, 32'h0000_0000);
		repeat (4) begin
			v = $random(seed);
			bus(1'b1, `SCAN_SEL_OFFSET, v, 0);
			bus(1'b0, `SCAN_SEL_OFFSET, 0, {16'h0000, v[15:0]});
		end
		bus(1'b1, 8'h20, $random(seed), 0);
		bus(1'b0, `SCAN_SEL_OFFSET, 0, {16'h0000, v[15:0]});
		$display("register test done");
		scan(16'h8001, 5);
		scan(16'h71c0, 7);
		scan(16'($random(seed)) | 16'h0400, 20);
		print_verdict();
	end
endmodule : scan_select_tb
